// ---- bench/tb_top.sv ----
// Self-checking bench for the timing event flags, driving every port directly.
// Assumes the design sources and the checker are compiled ahead of this file.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_i = 1'h0;
    logic       rst_n_i = 1'h0;
    logic [6:0] reg_addr_i = 7'h00;
    logic       reg_wr_i = 1'h0;
    logic       reg_rd_i = 1'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    wire  [7:0] reg_rdata_o;
    logic [3:0] ref_valid_i = 4'hF;
    logic [1:0] ref_select_i = 2'h0;
    logic       sel_ref_clk_i = 1'h0;
    logic [2:0] primary_loop_mode_i = 3'h0;
    logic [7:0] lo_bit [4] = '{8'h04, 8'h08, 8'h80, 8'h00};
    int         err_total = 0;
    int         comparisons = 0;
    timing_event_flags DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .ref_valid_i(ref_valid_i), .ref_select_i(ref_select_i),
        .sel_ref_clk_i(sel_ref_clk_i), .primary_loop_mode_i(primary_loop_mode_i));
    // Free-running 4 ns clock.
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // Case inequality so that an unknown never passes.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle strobes; the read data is looked at just after the edge that takes the read.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'h1;
        @(posedge clk_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'h1;
        @(posedge clk_i);
        reg_rd_i <= 1'h0;
        #1 chk(reg_rdata_o, exp);
    endtask
    task automatic rd2(input logic [7:0] lo, input logic [7:0] mi);
        rd(7'h05, lo);
        rd(7'h06, mi);
    endtask
    // The low byte is cleared last so a read follows its write two edges later.
    task automatic clear_all();
        wr(7'h06, 8'hFF);
        wr(7'h05, 8'hFF);
    endtask
    task automatic t_reset();
        rd2(8'hFF, 8'h7F);
        wr(7'h05, 8'h00);
        wr(7'h06, 8'h00);
        rd2(8'hFF, 8'h7F);
        clear_all();
        rd2(8'h73, 8'h3E);
    endtask
    // Each input drops out and then comes back, one at a time.
    task automatic t_ref();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            ref_valid_i[i % 4] <= ~ref_valid_i[i % 4];
            rd2(8'h73 | lo_bit[i % 4], (i % 4 == 3) ? 8'h3F : 8'h3E);
            clear_all();
        end
    endtask
    task automatic t_mode();
        for (int i = 1; i < 4; i++) begin
            @(posedge clk_i);
            primary_loop_mode_i <= 3'(i % 3);
            // The second byte is read first, so the checker sees the change and the read back to back.
            rd(7'h06, 8'hBE);
            rd(7'h05, 8'h73);
            clear_all();
        end
    endtask
    // A fresh selection learns an 8-cycle period, then the reference stops.
    task automatic t_fail(input logic [2:0] m, input logic [7:0] exp);
        @(posedge clk_i);
        primary_loop_mode_i <= m;
        ref_select_i <= ref_select_i + 2'h1;
        clear_all();
        repeat (8) begin
            repeat (4) @(posedge clk_i);
            sel_ref_clk_i <= ~sel_ref_clk_i;
        end
        rd2(8'h73, 8'h3E);
        repeat (30) @(posedge clk_i);
        rd2(8'h73, exp);
        clear_all();
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        t_reset();
        t_ref();
        t_mode();
        t_fail(3'h0, 8'h7E);
        t_fail(3'h2, 8'h3E);
        t_fail(3'h1, 8'h3E);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ---- bench/tef_flags_sva.sv ----
// Checker for the timing event flags: read data tied to strobes and flag events.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
`include "timing_event_flags_defs.vh"
module tef_checker (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic [6:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [3:0] ref_valid_i,
    input wire logic [2:0] primary_loop_mode_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Reads of each flag byte, and a clear of the first reference flag with its input quiet.
    sequence s_rd_low; reg_rd_i && reg_addr_i == `OFS_FLAGS_LOW; endsequence
    sequence s_rd_mid; reg_rd_i && reg_addr_i == `OFS_FLAGS_MID; endsequence
    sequence s_clr_one;
        reg_wr_i && reg_addr_i == `OFS_FLAGS_LOW && reg_wdata_i[2] && $stable(ref_valid_i[0]);
    endsequence
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    property p_low_unused; s_rd_low |=> reg_rdata_o[6:4] == 3'h7 && reg_rdata_o[1:0] == 2'h3;
    endproperty
    property p_mid_unused; s_rd_mid |=> reg_rdata_o[5:1] == 5'h1F; endproperty
    property p_ref_one; $changed(ref_valid_i[0]) ##1 s_rd_low |=> reg_rdata_o[2]; endproperty
    property p_ref_two; $changed(ref_valid_i[1]) ##1 s_rd_low |=> reg_rdata_o[3]; endproperty
    property p_ref_three; $changed(ref_valid_i[2]) ##1 s_rd_low |=> reg_rdata_o[7]; endproperty
    property p_mode; $changed(primary_loop_mode_i) ##1 s_rd_mid |=> reg_rdata_o[7]; endproperty
    // A quiet input around the clear keeps set-wins from masking a stuck flag.
    property p_clear;
        $stable(ref_valid_i[0]) ##1 s_clr_one ##1 $stable(ref_valid_i[0])
            ##1 (s_rd_low and $stable(ref_valid_i[0])) |=> !reg_rdata_o[2];
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_low_unused: assert property (p_low_unused) else $error("low unused bits wrong");
    a_mid_unused: assert property (p_mid_unused) else $error("mid unused bits wrong");
    a_ref_one: assert property (p_ref_one) else $error("ref one flag missing");
    a_ref_two: assert property (p_ref_two) else $error("ref two flag missing");
    a_ref_three: assert property (p_ref_three) else $error("ref three flag missing");
    a_mode: assert property (p_mode) else $error("mode change flag missing");
    a_clear: assert property (p_clear) else $error("flag survived write one");
endmodule
bind timing_event_flags tef_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .ref_valid_i(ref_valid_i),
    .primary_loop_mode_i(primary_loop_mode_i));
`default_nettype wire

// ---- rtl/latched_flag.v ----
// One sticky event flag: set by a hardware event, cleared by a software write of one.
// Assumes rst_n_i is an already synchronised active-low reset.
`default_nettype none

module latched_flag #(
    parameter RST_VAL = 1'b0
) (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire set_i,
    input  wire clr_i,
    output wire flag_o
);

    reg flag_ff;

    // The set has priority so an event in the clearing cycle is never lost.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_ff <= RST_VAL;
        end else if (set_i) begin
            flag_ff <= 1'b1;
        end else if (clr_i) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag_o = flag_ff;

endmodule

`default_nettype wire

// ---- rtl/timing_event_flags.v ----
// Latched event flags of the timing source: reference validity changes, primary loop
// mode change and main reference failure, read and cleared over the register port.
// Assumes all inputs are synchronous to clk_i and the register port strobes last one cycle.
//
// Behaviour
// - A flag at bits 2, 3 and 7 of the low byte sets whenever reference input one, two or three changes validity.
// - Bit 6 of the second byte flags failure of the reference selected for the primary loop.
// - The main reference failure flag is not raised while the primary loop is in free-run or holdover.
// - Each raised flag stays latched until software writes one to its bit; writing zero leaves it alone.
// - The low byte resets to all ones, with bits 6 to 4 and 1 to 0 unused.
// - The second byte resets to 0111 1111, so the mode change flag starts clear.
`default_nettype none
`include "timing_event_flags_defs.vh"

module timing_event_flags (
    input  wire                   clk_i,
    input  wire                   rst_n_i,
    input  wire [`REG_ADDR_W-1:0] reg_addr_i,
    input  wire                   reg_wr_i,
    input  wire                   reg_rd_i,
    input  wire [7:0]             reg_wdata_i,
    output wire [7:0]             reg_rdata_o,
    input  wire [3:0]             ref_valid_i,
    input  wire [1:0]             ref_select_i,
    input  wire                   sel_ref_clk_i,
    input  wire [2:0]             primary_loop_mode_i
);

    reg                   rst_meta_ff;
    reg                   rst_sync_ff;
    reg [7:0]             rdata_ff;
    reg [3:0]             valid_prev_ff;
    reg [2:0]             mode_prev_ff;
    reg                   armed_ff;
    reg                   ref_clk_prev_ff;
    reg [1:0]             select_prev_ff;
    reg [`GAP_CNT_W-1:0]  gap_cnt_ff;
    reg [`GAP_CNT_W-1:0]  period_ff;
    reg [1:0]             edges_seen_ff;
    reg                   fail_seen_ff;
    reg [`GAP_CNT_W-1:0]  nxt_gap_cnt;
    reg [`GAP_CNT_W+1:0]  miss_limit;

    wire                  rst_n;
    wire                  ref_edge;
    wire                  select_chg;
    wire                  loop_not_tracking;
    wire                  gap_expired;
    wire                  wr_low;
    wire                  wr_mid;
    wire [3:0]            valid_chg;
    wire                  mode_chg;
    wire                  main_fail_evt;
    wire [3:0]            ref_flag;
    wire                  mode_flag;
    wire                  fail_flag;
    wire [7:0]            flags_low;
    wire [7:0]            flags_mid;

    // Reset bytes as sized constants, so that each flag takes exactly one reset bit.
    localparam [7:0]             RST_LOW   = `RST_FLAGS_LOW;
    localparam [7:0]             RST_MID   = `RST_FLAGS_MID;
    // The period multiplier is sized to the limit, so the product keeps the limit's width.
    localparam [`GAP_CNT_W+1:0]  MISS_MULT = `MAIN_REF_MISS_CYC + 1;

    // Reset is asserted at once but released through two flops to avoid a ragged release.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    assign rst_n = rst_sync_ff;

    // History of the monitored levels; the first cycle after reset only loads it,
    // so the zeros loaded by reset never fake a change.
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            valid_prev_ff <= 4'h0;
            mode_prev_ff  <= 3'h0;
            armed_ff      <= 1'b0;
        end else begin
            valid_prev_ff <= ref_valid_i;
            mode_prev_ff  <= primary_loop_mode_i;
            armed_ff      <= 1'b1;
        end
    end

    assign valid_chg = armed_ff ? (ref_valid_i ^ valid_prev_ff) : 4'h0;
    assign mode_chg  = armed_ff && (primary_loop_mode_i != mode_prev_ff);

    // Missing-cycle detector on the selected reference.
    assign ref_edge          = sel_ref_clk_i && !ref_clk_prev_ff;
    assign select_chg        = ref_select_i != select_prev_ff;
    assign loop_not_tracking = (primary_loop_mode_i == `MODE_FREE_RUN) ||
                               (primary_loop_mode_i == `MODE_HOLDOVER);

    // A gap of one nominal period plus the missing cycles means that many edges are gone.
    always @* begin
        miss_limit  = {2'h0, period_ff} * MISS_MULT;
        nxt_gap_cnt = gap_cnt_ff;
        if (ref_edge || select_chg) begin
            nxt_gap_cnt = {`GAP_CNT_W{1'b0}};
        end else if (gap_cnt_ff != {`GAP_CNT_W{1'b1}}) begin
            nxt_gap_cnt = gap_cnt_ff + {{(`GAP_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign gap_expired = (edges_seen_ff == 2'h2) &&
                         ({2'b00, gap_cnt_ff} >= miss_limit);

    // One failure event per outage; the next edge or a reselection rearms it.
    assign main_fail_evt = gap_expired && !fail_seen_ff && !loop_not_tracking;

    // The period is learnt from the last full cycle, so a new selection needs two
    // edges before failure can be judged; a reference slower than the counter saturates.
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ref_clk_prev_ff <= 1'b0;
            select_prev_ff  <= 2'h0;
            gap_cnt_ff      <= {`GAP_CNT_W{1'b0}};
            period_ff       <= {`GAP_CNT_W{1'b0}};
            edges_seen_ff   <= 2'h0;
            fail_seen_ff    <= 1'b0;
        end else begin
            ref_clk_prev_ff <= sel_ref_clk_i;
            select_prev_ff  <= ref_select_i;
            gap_cnt_ff      <= nxt_gap_cnt;
            if (select_chg) begin
                edges_seen_ff <= 2'h0;
                fail_seen_ff  <= 1'b0;
            end else if (ref_edge) begin
                fail_seen_ff <= 1'b0;
                period_ff    <= gap_cnt_ff + {{(`GAP_CNT_W-1){1'b0}}, 1'b1};
                if (edges_seen_ff != 2'h2) begin
                    edges_seen_ff <= edges_seen_ff + 2'h1;
                end
            end else if (gap_expired) begin
                fail_seen_ff <= 1'b1;
            end
        end
    end

    // Write-one-to-clear decode; a zero bit in the write data leaves its flag alone.
    assign wr_low = reg_wr_i && (reg_addr_i == `OFS_FLAGS_LOW);
    assign wr_mid = reg_wr_i && (reg_addr_i == `OFS_FLAGS_MID);

    latched_flag #(.RST_VAL(RST_LOW[`BIT_REF_ONE_CHG])) u_flag_ref_one (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (valid_chg[0]),
        .clr_i   (wr_low && reg_wdata_i[`BIT_REF_ONE_CHG]),
        .flag_o  (ref_flag[0])
    );

    latched_flag #(.RST_VAL(RST_LOW[`BIT_REF_TWO_CHG])) u_flag_ref_two (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (valid_chg[1]),
        .clr_i   (wr_low && reg_wdata_i[`BIT_REF_TWO_CHG]),
        .flag_o  (ref_flag[1])
    );

    latched_flag #(.RST_VAL(RST_LOW[`BIT_REF_THREE_CHG])) u_flag_ref_three (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (valid_chg[2]),
        .clr_i   (wr_low && reg_wdata_i[`BIT_REF_THREE_CHG]),
        .flag_o  (ref_flag[2])
    );

    latched_flag #(.RST_VAL(RST_MID[`BIT_REF_FOUR_CHG])) u_flag_ref_four (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (valid_chg[3]),
        .clr_i   (wr_mid && reg_wdata_i[`BIT_REF_FOUR_CHG]),
        .flag_o  (ref_flag[3])
    );

    latched_flag #(.RST_VAL(RST_MID[`BIT_MAIN_REF_FAIL])) u_flag_main_fail (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (main_fail_evt),
        .clr_i   (wr_mid && reg_wdata_i[`BIT_MAIN_REF_FAIL]),
        .flag_o  (fail_flag)
    );

    latched_flag #(.RST_VAL(RST_MID[`BIT_MODE_CHG])) u_flag_mode (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .set_i   (mode_chg),
        .clr_i   (wr_mid && reg_wdata_i[`BIT_MODE_CHG]),
        .flag_o  (mode_flag)
    );

    // Unused positions read back their reset value, which is one in both bytes.
    assign flags_low = {ref_flag[2], 3'b111, ref_flag[1], ref_flag[0], 2'b11};
    assign flags_mid = {mode_flag, fail_flag, 5'b11111, ref_flag[3]};

    // Read data is registered so the output comes straight from a flop; it holds
    // until the next read, and unmapped addresses read as zero.
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `OFS_FLAGS_LOW: rdata_ff <= flags_low;
                `OFS_FLAGS_MID: rdata_ff <= flags_mid;
                default:        rdata_ff <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_o = rdata_ff;

endmodule

`default_nettype wire

// ---- rtl/timing_event_flags_defs.vh ----
// Register map, field positions, reset values and mode codes of the timing event flags.
// Assumes inclusion by bare name from the design files under rtl/.
`ifndef TIMING_EVENT_FLAGS_DEFS_VH
`define TIMING_EVENT_FLAGS_DEFS_VH

// Register offsets on the register port.
`define OFS_FLAGS_LOW        7'h05
`define OFS_FLAGS_MID        7'h06
`define REG_ADDR_W           7

// Field positions in the low flag byte.
`define BIT_REF_ONE_CHG      2
`define BIT_REF_TWO_CHG      3
`define BIT_REF_THREE_CHG    7

// Field positions in the second flag byte.
`define BIT_REF_FOUR_CHG     0
`define BIT_MAIN_REF_FAIL    6
`define BIT_MODE_CHG         7

// Reset values of the two flag bytes.
`define RST_FLAGS_LOW        8'hFF
`define RST_FLAGS_MID        8'h7F

// Primary loop operating mode codes seen on the mode input.
`define MODE_FREE_RUN        3'h1
`define MODE_HOLDOVER        3'h2

// Missing selected-reference cycles that declare the main reference failed.
`define MAIN_REF_MISS_CYC    2
`define GAP_CNT_W            16

`endif
